// ### hdl/enc_param_pkg.sv
// constants, opcodes and status codes for the encoder parameter command unit
// assumes a byte receiver/transmitter on the same clock outside the block
//
// Notes on behaviour
// - guard byte must match stored code, else reject
// - 4Ch returns status of named data field
// - 4Eh returns free nonvolatile memory bytes
// - 56h returns serial number and firmware version
// - 52h returns one-byte model identification code
// - no fault detected reports code 00h
// - corrupt partition table at init reports 03h
// - watchdog forced restart reports 07h
// - bad frame checksum discards command, reports 0Ah
// - wrong byte count for command reports 0Ch
// - argument outside permitted values reports 0Dh
// - write to protected field refused, 0Eh
// - resize of fixed-size field refused, 10h
// - word address beyond field end reports 11h
// - command on uncreated field reports 12h
// - speed too high for position reports 1Fh
// - analog amplitude violation reports 1Ch
// - critical transmitter current reports 1Dh
// - half-duplex RS-485 pair, sides take turns
package enc_param_pkg;

  // ****************************************
  // command bytes
  // ****************************************
  localparam logic [7:0] CMD_READ_DATA = 8'h4A;
  localparam logic [7:0] CMD_STORE_DATA = 8'h4B;
  localparam logic [7:0] CMD_FIELD_STATUS = 8'h4C;
  localparam logic [7:0] CMD_CREATE_FIELD = 8'h4D;
  localparam logic [7:0] CMD_FREE_MEM = 8'h4E;
  localparam logic [7:0] CMD_CHANGE_CODE = 8'h4F;
  localparam logic [7:0] CMD_READ_STATUS = 8'h50;
  localparam logic [7:0] CMD_MODEL_ID = 8'h52;
  localparam logic [7:0] CMD_SERIAL_VER = 8'h56;

  // ****************************************
  // frame byte counts including checksum, receive buffer depth and error reply flag
  // ****************************************
  localparam logic [3:0] LEN_READ_DATA = 4'h4;
  localparam logic [3:0] LEN_STORE_DATA = 4'h6;
  localparam logic [3:0] LEN_FIELD_STATUS = 4'h3;
  localparam logic [3:0] LEN_CREATE_FIELD = 4'h5;
  localparam logic [3:0] LEN_CHANGE_CODE = 4'h4;
  localparam logic [3:0] LEN_SHORT = 4'h2;
  localparam logic [3:0] BUF_DEPTH = 4'h8;
  localparam logic [7:0] ERR_FLAG = 8'h80;

  // ****************************************
  // status codes
  // ****************************************
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_PART_TABLE = 8'h03;
  localparam logic [7:0] ST_WATCHDOG = 8'h07;
  localparam logic [7:0] ST_CHECKSUM = 8'h0A;
  localparam logic [7:0] ST_UNKNOWN_CMD = 8'h0B;
  localparam logic [7:0] ST_BYTE_COUNT = 8'h0C;
  localparam logic [7:0] ST_BAD_ARG = 8'h0D;
  localparam logic [7:0] ST_WRITE_PROT = 8'h0E;
  localparam logic [7:0] ST_BAD_CODE = 8'h0F;
  localparam logic [7:0] ST_FIXED_SIZE = 8'h10;
  localparam logic [7:0] ST_ADDR_RANGE = 8'h11;
  localparam logic [7:0] ST_NO_FIELD = 8'h12;
  localparam logic [7:0] ST_AMPLITUDE = 8'h1C;
  localparam logic [7:0] ST_TX_CURRENT = 8'h1D;
  localparam logic [7:0] ST_OVERSPEED = 8'h1F;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] GUARD_RESET = 8'h55;
  localparam logic [15:0] FREE_RESET = 16'h0700;
  localparam logic [7:0] SYS_FIELD_SIZE = 8'h10;

  // ****************************************
  // fault input bit positions
  // ****************************************
  localparam int FLT_PART_TABLE = 0;
  localparam int FLT_WATCHDOG = 1;
  localparam int FLT_OVERSPEED = 2;
  localparam int FLT_AMPLITUDE = 3;
  localparam int FLT_TX_CURRENT = 4;
  localparam int FLT_COUNT = 5;

  typedef enum logic [2:0] {
    ST_RX = 3'b001,
    ST_EXEC = 3'b010,
    ST_TX = 3'b100
  } state_t;

endpackage

// ### hdl/fault_sync.sv
// two-stage synchroniser with rising-edge event per fault line
// assumes asynchronous level inputs
`timescale 1ns/1ps
module fault_sync #(
  parameter int WIDTH = 5
) (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] i_async, // raw fault levels
  output logic [WIDTH-1:0] o_rise // one-cycle event per line
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_line
      logic meta_ff;
      logic sync_ff;
      logic prev_ff;
      always_ff @(posedge i_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
          prev_ff <= 1'b0;
        end
        else
        begin
          meta_ff <= i_async[g];
          sync_ff <= meta_ff;
          prev_ff <= sync_ff;
        end
      end
      assign o_rise[g] = sync_ff & ~prev_ff;
    end
  endgenerate

endmodule // fault_sync

// ### hdl/encoder_param_command_unit.sv
// command interpreter of the encoder parameter channel
// assumes byte rx/tx on I_MCLK and an RS-485 transceiver driven by O_DE
`timescale 1ns/1ps
module encoder_param_command_unit #(
  parameter int NFIELDS = 4,
  parameter logic [7:0] MODEL_ID = 8'h01, // arbitrary value
  parameter logic [31:0] SERIAL_NO = 32'h0000_0001, // arbitrary value
  parameter logic [15:0] FW_VERSION = 16'h0001 // arbitrary value
) (
  input wire logic I_MCLK, // 40 MHz clock
  input wire logic I_RST_N, // async reset, active low
  input wire logic I_RX_VALID, // received byte strobe
  input wire logic [7:0] I_RX_DATA, // received byte
  input wire logic I_RX_LAST, // last byte of frame
  output logic O_TX_VALID, // reply byte valid
  output logic [7:0] O_TX_DATA, // reply byte
  output logic O_TX_LAST, // last reply byte
  input wire logic I_TX_READY, // transmitter takes byte
  output logic O_DE, // line driver enable
  input wire logic I_PART_TABLE_BAD, // partition table corrupt
  input wire logic I_WDOG_RESTART, // watchdog restart seen
  input wire logic I_OVERSPEED, // too fast for position
  input wire logic I_AMPL_FAULT, // analog amplitude fault
  input wire logic I_TX_CURR_CRIT // emitter current critical
);

  localparam int FW = (NFIELDS > 1) ? $clog2(NFIELDS) : 1;

  enc_param_pkg::state_t state_ff;
  logic [7:0] rx_buf_ff [0:7];
  logic [3:0] rx_cnt_ff;
  logic [7:0] rx_xor_ff;
  logic [7:0] tx_buf_ff [0:7];
  logic [3:0] tx_len_ff;
  logic [3:0] tx_idx_ff;
  logic [7:0] tx_data_ff;
  logic [7:0] err_ff;
  logic [7:0] guard_ff;
  logic [15:0] free_ff;
  logic [7:0] fld_size_ff [0:NFIELDS-1];
  logic [NFIELDS-1:0] fld_exist_ff;
  logic [NFIELDS-1:0] fld_wprot_ff;
  logic [NFIELDS-1:0] fld_fixed_ff;
  logic [enc_param_pkg::FLT_COUNT-1:0] flt_rise;

  // ****************************************
  // fault synchronisers
  // ****************************************
  fault_sync #(.WIDTH(enc_param_pkg::FLT_COUNT)) u_fault_sync (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_async({I_TX_CURR_CRIT, I_AMPL_FAULT, I_OVERSPEED, I_WDOG_RESTART, I_PART_TABLE_BAD}),
    .o_rise(flt_rise)
  );

  // ****************************************
  // command decode and checks
  // ****************************************
  logic [7:0] cmd;
  logic [7:0] arg_fld;
  logic [FW-1:0] fld;
  logic fld_in;
  logic [3:0] exp_len;
  logic known;
  logic [7:0] code;
  logic [7:0] rep [0:7];
  logic [3:0] rlen;
  logic [7:0] rcks;
  logic [15:0] avail;
  logic do_create;
  logic do_code;
  logic do_clr;

  always_comb
  begin
    cmd = rx_buf_ff[0];
    arg_fld = rx_buf_ff[1];
    fld = arg_fld[FW-1:0];
    fld_in = ({24'h0000_00, arg_fld} < NFIELDS);
    avail = free_ff + {8'h00, fld_size_ff[fld]};
    known = 1'b1;
    exp_len = enc_param_pkg::LEN_SHORT;
    unique case (cmd)
      enc_param_pkg::CMD_READ_DATA: exp_len = enc_param_pkg::LEN_READ_DATA;
      enc_param_pkg::CMD_STORE_DATA: exp_len = enc_param_pkg::LEN_STORE_DATA;
      enc_param_pkg::CMD_FIELD_STATUS: exp_len = enc_param_pkg::LEN_FIELD_STATUS;
      enc_param_pkg::CMD_CREATE_FIELD: exp_len = enc_param_pkg::LEN_CREATE_FIELD;
      enc_param_pkg::CMD_CHANGE_CODE: exp_len = enc_param_pkg::LEN_CHANGE_CODE;
      enc_param_pkg::CMD_FREE_MEM, enc_param_pkg::CMD_READ_STATUS,
      enc_param_pkg::CMD_MODEL_ID, enc_param_pkg::CMD_SERIAL_VER:
        exp_len = enc_param_pkg::LEN_SHORT;
      default:
        known = 1'b0;
    endcase
    code = enc_param_pkg::ST_OK;
    if (rx_xor_ff != 8'h00)
      code = enc_param_pkg::ST_CHECKSUM;
    else if (!known)
      code = enc_param_pkg::ST_UNKNOWN_CMD;
    else if (rx_cnt_ff != exp_len)
      code = enc_param_pkg::ST_BYTE_COUNT;
    else if (exp_len > enc_param_pkg::LEN_SHORT && !fld_in
             && cmd != enc_param_pkg::CMD_CHANGE_CODE)
      code = enc_param_pkg::ST_BAD_ARG;
    else
    begin
      unique case (cmd)
        enc_param_pkg::CMD_READ_DATA:
          if (!fld_exist_ff[fld])
            code = enc_param_pkg::ST_NO_FIELD;
          else if (rx_buf_ff[2] >= fld_size_ff[fld])
            code = enc_param_pkg::ST_ADDR_RANGE;
        enc_param_pkg::CMD_STORE_DATA:
          if (rx_buf_ff[3] != guard_ff)
            code = enc_param_pkg::ST_BAD_CODE;
          else if (!fld_exist_ff[fld])
            code = enc_param_pkg::ST_NO_FIELD;
          else if (fld_wprot_ff[fld])
            code = enc_param_pkg::ST_WRITE_PROT;
          else if (rx_buf_ff[2] >= fld_size_ff[fld])
            code = enc_param_pkg::ST_ADDR_RANGE;
        enc_param_pkg::CMD_FIELD_STATUS:
          if (!fld_exist_ff[fld])
            code = enc_param_pkg::ST_NO_FIELD;
        enc_param_pkg::CMD_CREATE_FIELD:
          if (rx_buf_ff[3] != guard_ff)
            code = enc_param_pkg::ST_BAD_CODE;
          else if (fld_fixed_ff[fld])
            code = enc_param_pkg::ST_FIXED_SIZE;
          else if (rx_buf_ff[2] == 8'h00 || {8'h00, rx_buf_ff[2]} > avail)
            code = enc_param_pkg::ST_BAD_ARG;
        enc_param_pkg::CMD_CHANGE_CODE:
          if (rx_buf_ff[1] != guard_ff)
            code = enc_param_pkg::ST_BAD_CODE;
        default:
          code = enc_param_pkg::ST_OK;
      endcase
    end
    do_create = (state_ff == enc_param_pkg::ST_EXEC) && (code == enc_param_pkg::ST_OK)
                && (cmd == enc_param_pkg::CMD_CREATE_FIELD);
    do_code = (state_ff == enc_param_pkg::ST_EXEC) && (code == enc_param_pkg::ST_OK)
              && (cmd == enc_param_pkg::CMD_CHANGE_CODE);
    do_clr = (state_ff == enc_param_pkg::ST_EXEC) && (code == enc_param_pkg::ST_OK)
             && (cmd == enc_param_pkg::CMD_READ_STATUS);
    // reply assembly
    for (int k = 0; k < 8; k++)
      rep[k] = 8'h00;
    rep[0] = cmd;
    rlen = 4'h2;
    if (code != enc_param_pkg::ST_OK)
    begin
      rep[0] = cmd | enc_param_pkg::ERR_FLAG;
      rep[1] = code;
      rlen = 4'h3;
    end
    else
    begin
      unique case (cmd)
        enc_param_pkg::CMD_READ_DATA, enc_param_pkg::CMD_STORE_DATA,
        enc_param_pkg::CMD_CREATE_FIELD:
        begin
          rep[1] = rx_buf_ff[1];
          rep[2] = rx_buf_ff[2];
          rlen = 4'h4;
        end
        enc_param_pkg::CMD_FIELD_STATUS:
        begin
          rep[1] = rx_buf_ff[1];
          rep[2] = fld_size_ff[fld];
          rep[3] = {5'b0_0000, fld_fixed_ff[fld], fld_wprot_ff[fld], fld_exist_ff[fld]};
          rlen = 4'h5;
        end
        enc_param_pkg::CMD_FREE_MEM:
        begin
          rep[1] = free_ff[15:8];
          rep[2] = free_ff[7:0];
          rlen = 4'h4;
        end
        enc_param_pkg::CMD_READ_STATUS, enc_param_pkg::CMD_MODEL_ID:
        begin
          rep[1] = (cmd == enc_param_pkg::CMD_MODEL_ID) ? MODEL_ID : err_ff;
          rlen = 4'h3;
        end
        enc_param_pkg::CMD_SERIAL_VER:
        begin
          rep[1] = SERIAL_NO[31:24];
          rep[2] = SERIAL_NO[23:16];
          rep[3] = SERIAL_NO[15:8];
          rep[4] = SERIAL_NO[7:0];
          rep[5] = FW_VERSION[15:8];
          rep[6] = FW_VERSION[7:0];
          rlen = 4'h8;
        end
        default:
          rlen = 4'h2;
      endcase
    end
    rcks = 8'h00;
    for (int k = 0; k < 7; k++)
      if (k < 32'(rlen) - 1)
        rcks = rcks ^ rep[k];
  end

  // ****************************************
  // sequencer: receive, execute, reply
  // ****************************************
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      state_ff <= enc_param_pkg::ST_RX;
    else
    begin
      unique case (state_ff)
        enc_param_pkg::ST_RX:
          if (I_RX_VALID && I_RX_LAST)
            state_ff <= enc_param_pkg::ST_EXEC;
        enc_param_pkg::ST_EXEC:
          state_ff <= enc_param_pkg::ST_TX;
        enc_param_pkg::ST_TX:
          if (I_TX_READY && tx_idx_ff == tx_len_ff - 4'h1)
            state_ff <= enc_param_pkg::ST_RX;
      endcase
    end
  end

  // bytes are ignored while the device owns the line
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rx_cnt_ff <= 4'h0;
      rx_xor_ff <= 8'h00;
      for (int k = 0; k < 8; k++)
        rx_buf_ff[k] <= 8'h00;
    end
    else if (state_ff == enc_param_pkg::ST_EXEC)
    begin
      rx_cnt_ff <= 4'h0;
      rx_xor_ff <= 8'h00;
    end
    else if (state_ff == enc_param_pkg::ST_RX && I_RX_VALID)
    begin
      if (rx_cnt_ff < enc_param_pkg::BUF_DEPTH)
        rx_buf_ff[rx_cnt_ff[2:0]] <= I_RX_DATA;
      if (rx_cnt_ff != 4'hF)
        rx_cnt_ff <= rx_cnt_ff + 4'h1;
      rx_xor_ff <= rx_xor_ff ^ I_RX_DATA;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      tx_len_ff <= 4'h0;
      tx_idx_ff <= 4'h0;
      tx_data_ff <= 8'h00;
      for (int k = 0; k < 8; k++)
        tx_buf_ff[k] <= 8'h00;
    end
    else if (state_ff == enc_param_pkg::ST_EXEC)
    begin
      for (int k = 0; k < 8; k++)
        tx_buf_ff[k] <= (k == 32'(rlen) - 1) ? rcks : rep[k];
      tx_len_ff <= rlen;
      tx_idx_ff <= 4'h0;
      tx_data_ff <= rep[0];
    end
    else if (state_ff == enc_param_pkg::ST_TX && I_TX_READY)
    begin
      tx_idx_ff <= tx_idx_ff + 4'h1;
      tx_data_ff <= tx_buf_ff[3'(tx_idx_ff + 4'h1)];
    end
  end

  assign O_TX_VALID = (state_ff == enc_param_pkg::ST_TX);
  assign O_TX_DATA = tx_data_ff;
  assign O_TX_LAST = O_TX_VALID && (tx_idx_ff == tx_len_ff - 4'h1);
  assign O_DE = (state_ff == enc_param_pkg::ST_TX);

  // ****************************************
  // data field table and guard code
  // ****************************************
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      guard_ff <= enc_param_pkg::GUARD_RESET;
      free_ff <= enc_param_pkg::FREE_RESET;
      fld_exist_ff <= NFIELDS'(1);
      fld_wprot_ff <= NFIELDS'(1);
      fld_fixed_ff <= NFIELDS'(1);
      for (int k = 0; k < NFIELDS; k++)
        fld_size_ff[k] <= (k == 0) ? enc_param_pkg::SYS_FIELD_SIZE : 8'h00;
    end
    else
    begin
      if (do_code)
        guard_ff <= rx_buf_ff[2];
      if (do_create)
      begin
        free_ff <= avail - {8'h00, rx_buf_ff[2]};
        fld_size_ff[fld] <= rx_buf_ff[2];
        fld_exist_ff[fld] <= 1'b1;
      end
    end
  end

  // ****************************************
  // latched status code, events win over clear
  // ****************************************
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      err_ff <= enc_param_pkg::ST_OK;
    else if (flt_rise[enc_param_pkg::FLT_TX_CURRENT])
      err_ff <= enc_param_pkg::ST_TX_CURRENT;
    else if (flt_rise[enc_param_pkg::FLT_AMPLITUDE])
      err_ff <= enc_param_pkg::ST_AMPLITUDE;
    else if (flt_rise[enc_param_pkg::FLT_OVERSPEED])
      err_ff <= enc_param_pkg::ST_OVERSPEED;
    else if (flt_rise[enc_param_pkg::FLT_WATCHDOG])
      err_ff <= enc_param_pkg::ST_WATCHDOG;
    else if (flt_rise[enc_param_pkg::FLT_PART_TABLE])
      err_ff <= enc_param_pkg::ST_PART_TABLE;
    else if (state_ff == enc_param_pkg::ST_EXEC && code != enc_param_pkg::ST_OK)
      err_ff <= code;
    else if (do_clr)
      err_ff <= enc_param_pkg::ST_OK;
  end

endmodule // encoder_param_command_unit

// ### sim/enc_param_cmd_sva.sv
// checker for the encoder parameter command unit
// sees only the top module ports, bound from the bench
`timescale 1ns/1ps
module enc_param_cmd_sva #(
  parameter logic [7:0] MODEL_ID = 8'h01
) (
  input wire logic I_MCLK, // clock
  input wire logic I_RST_N, // reset
  input wire logic I_RX_VALID, // rx strobe
  input wire logic [7:0] I_RX_DATA, // rx byte
  input wire logic I_RX_LAST, // rx last
  input wire logic O_TX_VALID, // tx valid
  input wire logic [7:0] O_TX_DATA, // tx byte
  input wire logic O_TX_LAST, // tx last
  input wire logic I_TX_READY, // tx ready
  input wire logic O_DE, // driver enable
  input wire logic I_PART_TABLE_BAD, // fault
  input wire logic I_WDOG_RESTART, // fault
  input wire logic I_OVERSPEED, // fault
  input wire logic I_AMPL_FAULT, // fault
  input wire logic I_TX_CURR_CRIT // fault
);
  // ****************************************
  // reply byte index, command and running xor
  // ****************************************
  logic [3:0] idx_ff;
  logic [7:0] cmd_ff;
  logic [7:0] sum_ff;
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      idx_ff <= 4'h0;
      cmd_ff <= 8'h00;
      sum_ff <= 8'h00;
    end
    else if (O_TX_VALID && I_TX_READY)
    begin
      idx_ff <= O_TX_LAST ? 4'h0 : idx_ff + 4'h1;
      sum_ff <= O_TX_LAST ? 8'h00 : sum_ff ^ O_TX_DATA;
      if (idx_ff == 4'h0)
        cmd_ff <= O_TX_DATA;
    end
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  a_de_follows: assert property (O_DE == O_TX_VALID)
    else $error("driver enable differs from reply valid");
  a_de_release: assert property (O_TX_VALID && O_TX_LAST && I_TX_READY |=> !O_DE)
    else $error("driver enable held after last reply byte");
  a_tx_holds: assert property (O_TX_VALID && !I_TX_READY |=>
    O_TX_VALID && $stable(O_TX_DATA) && $stable(O_TX_LAST))
    else $error("reply byte changed while stalled");
  a_answer_time: assert property (I_RX_VALID && I_RX_LAST && !O_TX_VALID |=>
    !O_TX_VALID ##1 O_TX_VALID) else $error("reply not two cycles after frame");
  a_cks_byte: assert property (O_TX_VALID && O_TX_LAST |-> O_TX_DATA == sum_ff)
    else $error("reply checksum wrong");
  a_model_id: assert property (O_TX_VALID && idx_ff == 4'h1 && cmd_ff == 8'h52
    |-> O_TX_DATA == MODEL_ID) else $error("model code wrong");
  a_err_short: assert property (O_TX_VALID && idx_ff == 4'h2 && cmd_ff[7]
    |-> O_TX_LAST) else $error("error reply not three bytes");
  a_err_code: assert property (O_TX_VALID && idx_ff == 4'h1 && cmd_ff[7] |->
    O_TX_DATA inside {8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12})
    else $error("error code outside set");
  a_free_len: assert property (O_TX_VALID && O_TX_LAST && cmd_ff == 8'h4e
    |-> idx_ff == 4'h3) else $error("free memory reply length wrong");
  a_serial_len: assert property (O_TX_VALID && O_TX_LAST && cmd_ff == 8'h56
    |-> idx_ff == 4'h7) else $error("serial reply length wrong");
endmodule // enc_param_cmd_sva

// ### sim/drive_ctl_model.sv
// drive controller model on the parameter link
// sends whole frames, takes reply bytes, prompt or slow ready
`timescale 1ns/1ps
module drive_ctl_model (
  input wire logic i_clk, // clock
  input wire logic i_tx_valid, // reply valid
  input wire logic [7:0] i_tx_data, // reply byte
  input wire logic i_tx_last, // reply last
  output logic o_rx_valid, // byte strobe
  output logic [7:0] o_rx_data, // byte
  output logic o_rx_last, // frame end
  output logic o_tx_ready // take reply byte
);
  bit slow;
  bit got_last;
  int unsigned tick;
  logic [7:0] reply_q[$];
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h5a;
    o_rx_last = 1'b0;
    o_tx_ready = 1'b0;
    slow = 1'b0;
    tick = 0;
  end
  always @(negedge i_clk)
  begin
    tick <= tick + 1;
    o_tx_ready <= !slow || (tick % 3 == 0);
  end
  always @(posedge i_clk)
  begin
    if (i_tx_valid && o_tx_ready)
    begin
      reply_q.push_back(i_tx_data);
      if (i_tx_last)
        got_last = 1'b1;
    end
  end
  // line released after the frame: data shows the inverse
  task automatic send_frame(input logic [7:0] f[$]);
    for (int i = 0; i < f.size(); i++)
    begin
      @(negedge i_clk);
      o_rx_valid = 1'b1;
      o_rx_data = f[i];
      o_rx_last = (i == f.size() - 1);
    end
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    o_rx_last = 1'b0;
    o_rx_data = ~o_rx_data;
  endtask
endmodule // drive_ctl_model

// ### sim/encoder_param_command_unit_bench.sv
// self-checking bench for the encoder parameter command unit
// controller model drives the link, a queue model predicts replies
`timescale 1ns/1ps
module encoder_param_command_unit_bench;
  logic clk, rst_n;
  logic rx_valid, rx_last, tx_valid, tx_last, tx_ready, de;
  logic [7:0] rx_data, tx_data;
  logic [4:0] flt;
  int fails, checks_done, seed, cyc;
  int ex[4], sz[4], wp[4], fx[4], free_b, guard, status;
  logic [7:0] fcode [5] = '{8'h03, 8'h07, 8'h1f, 8'h1c, 8'h1d};
  encoder_param_command_unit #(.NFIELDS(4), .MODEL_ID(8'h3c), // arbitrary value
    .SERIAL_NO(32'h1234_5678), .FW_VERSION(16'h0203)) dut ( // arbitrary values
    .I_MCLK(clk), .I_RST_N(rst_n), .I_RX_VALID(rx_valid), .I_RX_DATA(rx_data),
    .I_RX_LAST(rx_last), .O_TX_VALID(tx_valid), .O_TX_DATA(tx_data), .O_TX_LAST(tx_last),
    .I_TX_READY(tx_ready), .O_DE(de), .I_PART_TABLE_BAD(flt[0]), .I_WDOG_RESTART(flt[1]),
    .I_OVERSPEED(flt[2]), .I_AMPL_FAULT(flt[3]), .I_TX_CURR_CRIT(flt[4]));
  drive_ctl_model u_ctl (.i_clk(clk), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .i_tx_last(tx_last), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_rx_last(rx_last), .o_tx_ready(tx_ready));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t reply byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_len(input int got, input int exp);
    checks_done++;
    if (got != exp)
    begin
      fails++;
      $display("BAD %0t reply length %0d expected %0d", $time, got, exp);
    end
  endtask
  // ****************************************
  // reference model of one command
  // ****************************************
  task automatic model_cmd(input logic [7:0] f[$], input bit bad, output logic [7:0] r[$]);
    logic [7:0] c, code, x;
    int n, fl, need;
    c = f[0];
    n = f.size() + 1;
    fl = (f.size() > 1) ? f[1] : 0;
    code = 8'h00;
    r = {c};
    case (c)
      8'h4a, 8'h4f: need = 4;
      8'h4b: need = 6;
      8'h4c: need = 3;
      8'h4d: need = 5;
      8'h4e, 8'h50, 8'h52, 8'h56: need = 2;
      default: need = 0;
    endcase
    if (bad) code = enc_param_pkg::ST_CHECKSUM;
    else if (need == 0) code = enc_param_pkg::ST_UNKNOWN_CMD;
    else if (n != need) code = enc_param_pkg::ST_BYTE_COUNT;
    else if (fl >= 4 && c inside {8'h4a, 8'h4b, 8'h4c, 8'h4d}) code = enc_param_pkg::ST_BAD_ARG;
    else if (c inside {8'h4b, 8'h4d} && f[3] != guard) code = enc_param_pkg::ST_BAD_CODE;
    else if (c == 8'h4f && f[1] != guard) code = enc_param_pkg::ST_BAD_CODE;
    else if (c == 8'h4d && fx[fl]) code = enc_param_pkg::ST_FIXED_SIZE;
    else if (c == 8'h4d && (f[2] == 0 || f[2] > free_b + sz[fl])) code = enc_param_pkg::ST_BAD_ARG;
    else if (c inside {8'h4a, 8'h4b, 8'h4c} && !ex[fl]) code = enc_param_pkg::ST_NO_FIELD;
    else if (c == 8'h4b && wp[fl]) code = enc_param_pkg::ST_WRITE_PROT;
    else if (c inside {8'h4a, 8'h4b} && f[2] >= sz[fl]) code = enc_param_pkg::ST_ADDR_RANGE;
    else
      case (c)
        8'h4a, 8'h4b: r = {c, f[1], f[2]};
        8'h4c: r = {c, f[1], 8'(sz[fl]), 8'(fx[fl] * 4 + wp[fl] * 2 + ex[fl])};
        8'h4d:
        begin
          free_b = free_b + sz[fl] - f[2];
          ex[fl] = 1;
          sz[fl] = f[2];
          r = {c, f[1], f[2]};
        end
        8'h4e: r = {c, 8'(free_b >> 8), 8'(free_b)};
        8'h4f: guard = f[2];
        8'h50:
        begin
          r = {c, 8'(status)};
          status = 0;
        end
        8'h52: r = {c, 8'h3c};
        default: r = {c, 8'h12, 8'h34, 8'h56, 8'h78, 8'h02, 8'h03};
      endcase
    if (code != 8'h00)
    begin
      r = {c | enc_param_pkg::ERR_FLAG, code};
      status = code;
    end
    x = 8'h00;
    foreach (r[i]) x ^= r[i];
    r.push_back(x);
  endtask
  task automatic run(input logic [7:0] f[$], input bit bad);
    logic [7:0] r[$];
    logic [7:0] x;
    int w;
    model_cmd(f, bad, r);
    x = 8'h00;
    foreach (f[i]) x ^= f[i];
    f.push_back(bad ? ~x : x);
    u_ctl.reply_q = {};
    u_ctl.got_last = 1'b0;
    u_ctl.send_frame(f);
    w = 0;
    while (!u_ctl.got_last && w < 300)
    begin
      @(posedge clk);
      w++;
    end
    @(negedge clk);
    cmp_len(u_ctl.reply_q.size(), r.size());
    foreach (r[i]) if (i < u_ctl.reply_q.size()) cmp_byte(u_ctl.reply_q[i], r[i]);
  endtask
  initial
  begin
    seed = 42261;
    rst_n = 1'b0;
    flt = 5'h00;
    ex = '{1, 0, 0, 0};
    sz = '{16, 0, 0, 0};
    wp = '{1, 0, 0, 0};
    fx = '{1, 0, 0, 0};
    free_b = 1792;
    guard = 8'h55;
    status = 0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    run({8'h50}, 0);
    run({8'h52}, 0);
    run({8'h56}, 0);
    run({8'h4e}, 0);
    run({8'h4c, 8'h00}, 0);
    run({8'h52}, 1);
    run({8'h50}, 0);
    run({8'h41}, 0);
    run({8'h50}, 0);
    run({8'h4e, 8'h00}, 0);
    run({8'h4a, 8'h04, 8'h00}, 0);
    run({8'h4d, 8'h01, 8'h00, 8'h55}, 0);
    run({8'h4b, 8'h00, 8'h00, 8'h55, 8'h9c}, 0);
    run({8'h4d, 8'h00, 8'h20, 8'h55}, 0);
    run({8'h4a, 8'h01, 8'h00}, 0);
    run({8'h4d, 8'h01, 8'h20, 8'h33}, 0);
    run({8'h4d, 8'h01, 8'h20, 8'h55}, 0);
    run({8'h4e}, 0);
    run({8'h4c, 8'h01}, 0);
    u_ctl.slow = 1'b1;
    repeat (12) run({8'h4a, 8'h01, 8'($random(seed)) & 8'h3f}, 0);
    run({8'h4f, 8'h55, 8'ha7}, 0);
    run({8'h4b, 8'h01, 8'h05, 8'h55, 8'h11}, 0);
    run({8'h4b, 8'h01, 8'h05, 8'ha7, 8'($random(seed))}, 0);
    u_ctl.slow = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      flt[i] = 1'b1;
      repeat (8) @(negedge clk);
      flt[i] = 1'b0;
      status = fcode[i];
      run({8'h50}, 0);
    end
    flt = 5'h1f;
    repeat (8) @(negedge clk);
    flt = 5'h00;
    status = fcode[4];
    run({8'h50}, 0);
    run({8'h50}, 0);
    report_and_stop();
  end
endmodule // encoder_param_command_unit_bench
bind encoder_param_command_unit enc_param_cmd_sva #(.MODEL_ID(MODEL_ID)) u_sva (
  .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_RX_VALID(I_RX_VALID), .I_RX_DATA(I_RX_DATA),
  .I_RX_LAST(I_RX_LAST), .O_TX_VALID(O_TX_VALID), .O_TX_DATA(O_TX_DATA),
  .O_TX_LAST(O_TX_LAST), .I_TX_READY(I_TX_READY), .O_DE(O_DE),
  .I_PART_TABLE_BAD(I_PART_TABLE_BAD), .I_WDOG_RESTART(I_WDOG_RESTART),
  .I_OVERSPEED(I_OVERSPEED), .I_AMPL_FAULT(I_AMPL_FAULT), .I_TX_CURR_CRIT(I_TX_CURR_CRIT));
